/* acdsp_dev.sv */
// Device end of the addressed current DAC serial port: receives 16-bit
// words, checks the strapped address and holds the 12-bit output code.
// Assumes every link wire and pin is asynchronous to REF_CLK_I and that
// the serial clock half-period spans several system clock cycles.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Sample data on each rising serial clock.
// - Rising select takes the sixteen-bit command word.
// - Extra bits push out earliest; keep last sixteen.
// - Address match loads twelve code bits.
// - Lead bit zero, then straps 2,1,0.
// - Word goes MSB first, address then code.
// - Eight distinct addresses share one bus.
// - Same-address devices update together.
// - Standby disables output, keeps stored code.
// - Standby release restores output within six microseconds.
// - Reset low holds the code at zero.
// - Words ignored during standby or reset.
// - Reset clears code without any serial edge.
// - Select is active low; shift only while low.
module acdsp_dev #(
   parameter int unsigned RESTORE_CYC = acdsp_pkg::RESTORE_CYC
) (
   input  wire logic                               REF_CLK_I,
   input  wire logic                               RST_N_I,
   acdsp_if.dev                                    link_if,
   input  wire logic [acdsp_pkg::ADDR_BITS-1:0]    STRAP_ADDR_I,
   input  wire logic                               STANDBY_N_I,
   input  wire logic                               RESET_N_I,
   output logic      [acdsp_pkg::CODE_BITS-1:0]    CODE_O,
   output logic                                    OUT_EN_O,
   output logic                                    LOAD_O
);

   // Refuse a restore budget shorter than the synchroniser path.
   if (RESTORE_CYC < acdsp_pkg::SYNC_STAGES + 2) begin : g_restore_chk
      $error("Restore budget is shorter than the standby input path.");
   end

   // The word must split exactly into lead bit, address field and code,
   // or the field positions below would overlap or leave a gap.
   if (acdsp_pkg::WORD_BITS !=
       1 + acdsp_pkg::ADDR_BITS + acdsp_pkg::CODE_BITS) begin : g_layout_chk
      $error("Word layout does not split into lead bit, address and code.");
   end

   // The bit counter must reach a full word without wrapping.
   if ((1 << acdsp_pkg::CNT_BITS) <= acdsp_pkg::WORD_BITS) begin : g_cnt_chk
      $error("Bit counter is too narrow for a full word.");
   end

   // The bank below is built with exactly two flops per input.
   if (acdsp_pkg::SYNC_STAGES != 2) begin : g_sync_chk
      $error("Synchroniser bank supports exactly two stages.");
   end

   // Raw inputs gathered for the synchroniser bank.
   wire  [7:0] raw_in;
   logic [7:0] sync1_r;
   logic [7:0] sync2_r;

   assign raw_in = {link_if.serial_clk, link_if.select_n, link_if.serial_data_in,
                    STRAP_ADDR_I, STANDBY_N_I, RESET_N_I};

   // Two-flop synchroniser per input; the first flop feeds only the second.
   // Select resets to its idle high level and the clock resets high, so no false select or clock rise follows reset.
   genvar gi;
   for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge REF_CLK_I) begin
         if (!RST_N_I) begin
            sync1_r[gi] <= acdsp_pkg::SYNC_RST[gi];
            sync2_r[gi] <= acdsp_pkg::SYNC_RST[gi];
         end else begin
            sync1_r[gi] <= raw_in[gi];
            sync2_r[gi] <= sync1_r[gi];
         end
      end
   end

   // Named views of the synchronised inputs.
   wire                                 sclk_s;
   wire                                 sel_n_s;
   wire                                 sdi_s;
   wire  [acdsp_pkg::ADDR_BITS-1:0]     strap_s;
   wire                                 standby_n_s;
   wire                                 reset_n_s;

   assign sclk_s      = sync2_r[7];
   assign sel_n_s     = sync2_r[6];
   assign sdi_s       = sync2_r[5];
   assign strap_s     = sync2_r[4:2];
   assign standby_n_s = sync2_r[1];
   assign reset_n_s   = sync2_r[0];

   // Delayed copies for edge detection.
   logic sclk_d_r;
   logic sel_n_d_r;

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         sclk_d_r  <= acdsp_pkg::SYNC_RST[7];
         sel_n_d_r <= acdsp_pkg::SYNC_RST[6];
      end else begin
         sclk_d_r  <= sclk_s;
         sel_n_d_r <= sel_n_s;
      end
   end

   // Edge and mode decoding. A select rise that lands with the last clock
   // fall still sees the full count, which only clears one cycle later.
   // Edge and mode decoding.
   wire sclk_rise;
   wire sel_rise;
   wire port_active;
   wire shift_en;

   assign sclk_rise   = sclk_s & ~sclk_d_r;
   assign sel_rise    = sel_n_s & ~sel_n_d_r;
   assign port_active = standby_n_s & reset_n_s;
   assign shift_en    = sclk_rise & ~sel_n_s & port_active;

   // Input shift register and bit counter.
   logic [acdsp_pkg::WORD_BITS-1:0] shift_r;
   logic [acdsp_pkg::WORD_BITS-1:0] shift_nxt;
   logic [acdsp_pkg::CNT_BITS-1:0]  cnt_r;
   logic [acdsp_pkg::CNT_BITS-1:0]  cnt_nxt;
   wire                             cnt_full;

   assign cnt_full = (cnt_r == acdsp_pkg::CNT_BITS'(acdsp_pkg::WORD_BITS));

   // New bits enter at the bottom, so the oldest fall off the top.
   // Shifting goes on past a full word, so an overlong word keeps its last bits.
   assign shift_nxt = shift_en ?
                      {shift_r[acdsp_pkg::WORD_BITS-2:0], sdi_s} : shift_r;

   // The count saturates at a full word and restarts between words or
   // whenever the port is inactive, so a word cut by standby is dropped.
   assign cnt_nxt = (sel_n_s || !port_active) ? '0 :
                    (shift_en && !cnt_full) ? cnt_r + acdsp_pkg::CNT_BITS'(1) : cnt_r;

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         shift_r <= '0;
         cnt_r   <= '0;
      end else begin
         shift_r <= shift_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Checks the address field of a received word against the straps.
   function automatic logic addr_match(
      input logic [acdsp_pkg::WORD_BITS-1:0] word,
      input logic [acdsp_pkg::ADDR_BITS-1:0] strap
   );
      logic lead_ok;
      lead_ok    = ~word[acdsp_pkg::LEAD_ZERO_POS];
      addr_match = lead_ok && (word[acdsp_pkg::ADDR_MSB:acdsp_pkg::ADDR_LSB] == strap);
   endfunction

   // Word acceptance: full word, good lead bit, own address, port active.
   // A short word or a word cut by standby never reaches a full count.
   wire word_hit;
   wire [acdsp_pkg::CODE_BITS-1:0] word_code;

   assign word_hit  = sel_rise && cnt_full && port_active &&
                      addr_match(shift_r, strap_s);
   assign word_code = shift_r[acdsp_pkg::CODE_BITS-1:0];

   // Data register: cleared while reset is low, otherwise loaded only on
   // an accepted word; any other word leaves it untouched.
   // Every device on the link makes the same decision on the same edge, so
   // devices strapped alike load one word in the same cycle.
   logic [acdsp_pkg::CODE_BITS-1:0] code_r;
   logic [acdsp_pkg::CODE_BITS-1:0] code_nxt;

   assign code_nxt = !reset_n_s ? acdsp_pkg::CODE_RST :
                     word_hit   ? word_code : code_r;

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         code_r <= acdsp_pkg::CODE_RST;
      end else begin
         code_r <= code_nxt;
      end
   end

   // Output stage enable and load strobe. The code register is kept in
   // standby, so the output returns to it as soon as standby ends.
   // Standby gates only the enable; it never touches the stored code.
   logic out_en_r;
   logic load_r;

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         out_en_r <= 1'b0;
         load_r   <= 1'b0;
      end else begin
         out_en_r <= standby_n_s;
         load_r   <= word_hit;
      end
   end

   assign CODE_O   = code_r;
   assign OUT_EN_O = out_en_r;
   assign LOAD_O   = load_r;

endmodule
`default_nettype wire

/* acdsp_pkg.sv */
// Shared constants for the addressed current DAC serial port: the word
// layout, timing counts and the host controller's register map.
// Assumes a 200 MHz system clock on both ends of the link.
package acdsp_pkg;
   // Serial word layout, most significant bit first.
   localparam int unsigned WORD_BITS    = 16;
   localparam int unsigned CODE_BITS    = 12;
   localparam int unsigned ADDR_BITS    = 3;
   localparam int unsigned LEAD_ZERO_POS = 15;
   localparam int unsigned ADDR_MSB     = 14;
   localparam int unsigned ADDR_LSB     = 12;
   localparam int unsigned CNT_BITS     = 5;

   // System clock period and the standby restore limit.
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned RESTORE_US    = 6;
   localparam int unsigned RESTORE_CYC   = (RESTORE_US * 1000000) / CLK_PERIOD_PS;

   // Synchroniser depth and host half-period of the serial clock.
   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned HALF_DIV      = 8;
   localparam int unsigned HALF_DIV_MIN  = 4;

   // Reset values.
   localparam logic [CODE_BITS-1:0] CODE_RST  = 12'h000;
   localparam logic [7:0]           SYNC_RST  = 8'hC3;

   // Host controller register map (byte addresses) and fields.
   localparam logic [7:0]  REG_CMD      = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam int unsigned STAT_BUSY    = 0;
   localparam int unsigned STAT_DONE    = 1;
   localparam logic [31:0] CMD_RST      = 32'h0000_0000;
endpackage

/* acdsp_if.sv */
// Three-wire serial link between the host controller and the DAC port.
// Assumes the host drives all three wires and the device only listens.
`timescale 1ns/1ps
`default_nettype none
interface acdsp_if;
   logic serial_clk;
   logic serial_data_in;
   logic select_n;

   // Host end drives the wires.
   modport host (
      output serial_clk,
      output serial_data_in,
      output select_n
   );

   // Device end samples the wires.
   modport dev (
      input  serial_clk,
      input  serial_data_in,
      input  select_n
   );
endinterface
`default_nettype wire

/* acdsp_host.sv */
// Host end of the addressed current DAC serial link: an APB slave takes a
// command word from software and sends it as a 16-bit serial frame.
// Assumes APB on REF_CLK_I and a device that samples on rising serial clock.
`timescale 1ns/1ps
`default_nettype none
module acdsp_host #(
   parameter int unsigned HALF_DIV = acdsp_pkg::HALF_DIV
) (
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_N_I,
   acdsp_if.host            link_if,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O
);

   // A half-period must outlast the device's synchroniser path.
   if (HALF_DIV < acdsp_pkg::HALF_DIV_MIN) begin : g_div_chk
      $error("HALF_DIV is too small for the receiving synchroniser.");
   end

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LOW  = 4'h2,
      ST_HIGH = 4'h4,
      ST_END  = 4'h8
   } acdsp_state_t;

   acdsp_state_t state_r;
   acdsp_state_t state_nxt;

   // APB decoding; one wait state, the access completes when pready is seen.
   logic        pready_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   logic [31:0] cmd_r;
   logic        done_r;
   wire         access;
   wire         commit;
   wire         hit_cmd;
   wire         hit_stat;
   wire         busy;
   wire         start;
   wire         done_clr;
   wire         bad;
   wire  [31:0] rd_mux;

   assign access   = PSEL_I & PENABLE_I;
   assign commit   = access & pready_r;
   assign hit_cmd  = (PADDR_I == acdsp_pkg::REG_CMD);
   assign hit_stat = (PADDR_I == acdsp_pkg::REG_STATUS);
   assign busy     = (state_r != ST_IDLE);
   assign bad      = ~(hit_cmd | hit_stat) | (PWRITE_I & hit_cmd & busy);
   assign start    = commit & PWRITE_I & hit_cmd & ~pslverr_r;  // Refused writes never start.
   assign done_clr = commit & PWRITE_I & hit_stat & PWDATA_I[acdsp_pkg::STAT_DONE];
   assign rd_mux   = hit_cmd  ? cmd_r :
                     hit_stat ? {30'h0000_0000, done_r, busy} : 32'h0000_0000;

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= access & ~pready_r;
         prdata_r  <= (access & ~pready_r & ~PWRITE_I) ? rd_mux : prdata_r;
         pslverr_r <= access & ~pready_r & bad;
      end
   end

   // Frame sequencing: divider tick, bit counter and output wires.
   logic [15:0]                      div_r;
   logic [acdsp_pkg::WORD_BITS-1:0]  sh_r;
   logic [acdsp_pkg::CNT_BITS-1:0]   bits_r;
   logic                             sclk_r;
   logic                             sdi_r;
   logic                             sel_n_r;
   wire                              tick;
   wire                              last_bit;

   assign tick     = (div_r == 16'(HALF_DIV - 1));
   assign last_bit = (bits_r == acdsp_pkg::CNT_BITS'(acdsp_pkg::WORD_BITS - 1));

   // Next state: low half, high half per bit, then select rise and a gap.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: state_nxt = start ? ST_LOW : ST_IDLE;
         ST_LOW:  state_nxt = tick ? ST_HIGH : ST_LOW;
         ST_HIGH: state_nxt = !tick ? ST_HIGH : (last_bit ? ST_END : ST_LOW);
         ST_END:  state_nxt = tick ? ST_IDLE : ST_END;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         state_r <= ST_IDLE;
         div_r   <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         div_r   <= (state_r == ST_IDLE || tick) ? 16'h0000 : div_r + 16'h0001;
      end
   end

   // Word is lead zero, three address bits, then twelve code bits, MSB first.
   wire [acdsp_pkg::WORD_BITS-1:0] frame;
   assign frame = {1'b0, PWDATA_I[14:12], PWDATA_I[11:0]};

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         cmd_r   <= acdsp_pkg::CMD_RST;
         sh_r    <= '0;
         bits_r  <= '0;
         sclk_r  <= 1'b0;
         sdi_r   <= 1'b0;
         sel_n_r <= 1'b1;
      end else if (start) begin
         cmd_r   <= {17'h0_0000, frame[14:0]};
         sh_r    <= {frame[14:0], 1'b0};
         bits_r  <= '0;
         sdi_r   <= frame[15];
         sel_n_r <= 1'b0;
      end else if (tick && state_r == ST_LOW) begin
         sclk_r  <= 1'b1;
      end else if (tick && state_r == ST_HIGH) begin
         sclk_r  <= 1'b0;
         sdi_r   <= last_bit ? 1'b0 : sh_r[acdsp_pkg::WORD_BITS-1];
         sh_r    <= {sh_r[acdsp_pkg::WORD_BITS-2:0], 1'b0};
         bits_r  <= bits_r + acdsp_pkg::CNT_BITS'(1);
         sel_n_r <= last_bit;
      end
   end

   // Sticky done flag; a frame ending in the clearing cycle still sets it.
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         done_r <= 1'b0;
      end else begin
         done_r <= (state_r == ST_END && tick) | (done_r & ~done_clr);
      end
   end

   assign link_if.serial_clk     = sclk_r;
   assign link_if.serial_data_in = sdi_r;
   assign link_if.select_n       = sel_n_r;
   assign PRDATA_O  = prdata_r;
   assign PREADY_O  = pready_r;
   assign PSLVERR_O = pslverr_r;

endmodule
`default_nettype wire

/* acdsp_sva.sv */
// Checker for the serial link and the first device's outputs.
// Assumes host and device share REF_CLK_I and RST_N_I.
`timescale 1ns/1ps
`default_nettype none
module acdsp_sva (
   input wire logic                            REF_CLK_I,
   input wire logic                            RST_N_I,
   input wire logic                            serial_clk,
   input wire logic                            serial_data_in,
   input wire logic                            select_n,
   input wire logic                            STANDBY_N_I,
   input wire logic                            RESET_N_I,
   input wire logic [acdsp_pkg::CODE_BITS-1:0] CODE_O,
   input wire logic                            OUT_EN_O,
   input wire logic                            LOAD_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic       sclk_q;
   logic [4:0] cnt_r;
   logic [2:0] since_r;
   // Counts serial clock rises in a frame and cycles since select was low.
   always_ff @(posedge REF_CLK_I) begin
      sclk_q <= serial_clk;
      if (!RST_N_I || select_n) cnt_r <= 5'h00;
      else if (serial_clk && !sclk_q) cnt_r <= cnt_r + 5'h01;
      if (!RST_N_I || !select_n) since_r <= 3'h0;
      else if (since_r != 3'h7) since_r <= since_r + 3'h1;
   end
   // Link framing and device response timing.
   a_sclk_idle_low: assert property (select_n |-> !serial_clk)
      else $error("serial clock moved while deselected");
   a_data_stable: assert property ($rose(serial_clk) |-> $stable(serial_data_in))
      else $error("data changed at serial clock rise");
   a_lead_zero: assert property ($fell(select_n) |-> !serial_data_in)
      else $error("frame does not start with a zero bit");
   a_word_count: assert property ($rose(select_n) |-> cnt_r == 5'h10)
      else $error("frame length is not sixteen bits");
   a_load_delay: assert property (LOAD_O |-> since_r inside {[3'h3:3'h6]})
      else $error("load not tied to select rise");
   a_load_pulse: assert property (LOAD_O |=> !LOAD_O)
      else $error("load pulse longer than one cycle");
   a_code_cause: assert property ($changed(CODE_O) |-> LOAD_O || CODE_O == 12'h000)
      else $error("code changed without a load");
   a_reset_zero: assert property (!RESET_N_I [*4] |-> CODE_O == 12'h000)
      else $error("code not cleared by reset pin");
   a_standby_off: assert property (!STANDBY_N_I [*5] |-> !OUT_EN_O)
      else $error("output enabled during standby");
   a_standby_on: assert property (STANDBY_N_I [*5] |-> OUT_EN_O)
      else $error("output not restored after standby");
   // Main scenarios reached.
   c_frame: cover property ($rose(select_n));
   c_load: cover property (LOAD_O);
   c_standby: cover property ($fell(OUT_EN_O));
   c_pin_reset: cover property (!RESET_N_I ##1 RESET_N_I);
endmodule
`default_nettype wire

/* acdsp_tb_top.sv */
// Testbench: APB drives the host, which feeds two devices on one link;
// a third device sits on a link driven directly by the bench.
`timescale 1ns/1ps
`default_nettype none
module acdsp_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  strap_a = 3'h5;
   logic [2:0]  strap_b = 3'h2;
   logic        stby_n = 1'b1;
   logic        dres_n = 1'b1;
   logic [11:0] code_a;
   logic [11:0] code_b;
   logic [11:0] code_c;
   logic [11:0] c;
   logic [11:0] cb_exp = 12'h000;
   logic        oen_a;
   logic        load_a;
   logic [31:0] rd;
   logic        er;
   logic [11:0] q_exp[$];
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;
   acdsp_if link ();
   acdsp_if link2 ();
   acdsp_host u_acdsp_host (.REF_CLK_I(clk), .RST_N_I(rst_n), .link_if(link.host),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
   acdsp_dev u_acdsp_dev (.REF_CLK_I(clk), .RST_N_I(rst_n), .link_if(link.dev),
      .STRAP_ADDR_I(strap_a), .STANDBY_N_I(stby_n), .RESET_N_I(dres_n),
      .CODE_O(code_a), .OUT_EN_O(oen_a), .LOAD_O(load_a));
   acdsp_dev u_acdsp_dev_2 (.REF_CLK_I(clk), .RST_N_I(rst_n), .link_if(link.dev),
      .STRAP_ADDR_I(strap_b), .STANDBY_N_I(stby_n), .RESET_N_I(dres_n),
      .CODE_O(code_b), .OUT_EN_O(), .LOAD_O());
   acdsp_dev u_acdsp_dev_3 (.REF_CLK_I(clk), .RST_N_I(rst_n), .link_if(link2.dev),
      .STRAP_ADDR_I(3'h3), .STANDBY_N_I(stby_n), .RESET_N_I(dres_n),
      .CODE_O(code_c), .OUT_EN_O(), .LOAD_O());
   acdsp_sva u_acdsp_sva (.REF_CLK_I(clk), .RST_N_I(rst_n), .serial_clk(link.serial_clk),
      .serial_data_in(link.serial_data_in), .select_n(link.select_n),
      .STANDBY_N_I(stby_n), .RESET_N_I(dres_n), .CODE_O(code_a), .OUT_EN_O(oen_a),
      .LOAD_O(load_a));
   // Clock and the hang limit.
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // Each load of the first device takes the oldest expected code.
   always @(posedge clk) begin
      if (load_a === 1'b1) begin
         if (q_exp.size() == 0) check("spurious_load", 32'h1, 32'h0);
         else check("code_a", {20'h0, code_a}, {20'h0, q_exp.pop_front()});
      end
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One APB transfer; read data and error are taken at the ready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Starts a frame and notes the code that the first device should load.
   task start(input logic [2:0] a, input logic [11:0] d);
      apb(1'b1, 8'h00, {17'h0, a, d});
      check("cmd_err", {31'h0, er}, 32'h0);
      if (a == strap_a && stby_n && dres_n) q_exp.push_back(d);
   endtask
   // Waits for the frame to finish, clears done, lets the device settle.
   task wait_done();
      rd = 32'h0;
      while (rd[1] !== 1'b1) apb(1'b0, 8'h04, 32'h0);
      apb(1'b1, 8'h04, 32'h2);
      repeat (10) @(posedge clk);
   endtask
   task send(input logic [2:0] a, input logic [11:0] d);
      start(a, d);
      wait_done();
   endtask
   // Bench-made frame of n bits on the second link, off the clock's phase.
   task raw(input logic [19:0] w, input int n);
      @(posedge clk);
      #1.3;
      link2.select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         link2.serial_data_in = w[i];
         #32 link2.serial_clk = 1'b1;
         #32 link2.serial_clk = 1'b0;
      end
      link2.select_n = 1'b1;
      link2.serial_data_in = ~w[0];
      repeat (12) @(posedge clk);
   endtask
   // Main sequence.
   initial begin
      link2.select_n = 1'b1;
      link2.serial_clk = 1'b0;
      link2.serial_data_in = 1'b0;
      void'($urandom(32'h917C0F4D));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("code_rst", {20'h0, code_a}, 32'h0);
      check("oen_rst", {31'h0, oen_a}, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      check("status_rst", rd, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      check("unmapped_err", {31'h0, er}, 32'h1);
      check("unmapped_rd", rd, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         c = 12'($urandom);
         start(strap_a, c);
         apb(1'b1, 8'h00, {17'h0, strap_a, ~c});
         check("busy_err", {31'h0, er}, 32'h1);
         wait_done();
         apb(1'b0, 8'h00, 32'h0);
         check("cmd_rd", rd, {17'h0, strap_a, c});
      end
      $display("test random codes done");
      for (int a = 0; a < 8; a++) begin
         c = 12'($urandom);
         send(3'(a), c);
         if (3'(a) == strap_b) cb_exp = c;
         check("code_b", {20'h0, code_b}, {20'h0, cb_exp});
      end
      $display("test addresses done");
      strap_b <= strap_a;
      repeat (4) @(posedge clk);
      send(strap_a, 12'hFFF);
      check("shared", {20'h0, code_b}, 32'hFFF);
      $display("test shared address done");
      stby_n <= 1'b0;
      repeat (5) @(posedge clk);
      check("oen_sb", {31'h0, oen_a}, 32'h0);
      send(strap_a, 12'h800);
      check("code_sb", {20'h0, code_a}, 32'hFFF);
      stby_n <= 1'b1;
      repeat (5) @(posedge clk);
      check("oen_back", {31'h0, oen_a}, 32'h1);
      $display("test standby done");
      dres_n <= 1'b0;
      repeat (5) @(posedge clk);
      check("code_rn", {20'h0, code_a}, 32'h0);
      send(strap_a, 12'h123);
      check("code_rn_w", {20'h0, code_a}, 32'h0);
      dres_n <= 1'b1;
      repeat (4) @(posedge clk);
      send(strap_a, 12'h456);
      $display("test reset pin done");
      raw(20'hA35A5, 20);
      check("long_word", {20'h0, code_c}, 32'h5A5);
      raw(20'h0B111, 16);
      check("lead_one", {20'h0, code_c}, 32'h5A5);
      raw(20'h03222, 15);
      check("short_word", {20'h0, code_c}, 32'h5A5);
      $display("test raw link done");
      check("q_empty", 32'(q_exp.size()), 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
